// *** src/fault_cfg_map.svh ***
// offsets, field positions, reset values and timing counts of the fault setting word
//Contract
//RULE_01: no-motor condition must persist for chosen deglitch
//RULE_02: mode 0 recirculates, asserts fault, resumes next cycle
//RULE_03: mode 1 like mode 0, fault pin inactive
//RULE_04: modes 2,3 hold until voltage below threshold
//RULE_05: software uses modes 2,3 only with high-side modulation
//RULE_06: retry modes resume after programmed cycles; 5 silent
//RULE_07: mode 6 only reports, no driver action
//RULE_08: mode 7 and above disable limiting
//RULE_09: lock threshold is code times 0.1 V
//RULE_10: retry count field gives 0 to 7 cycles
//RULE_11: lock overcurrent qualified by 4-bit deglitch time
//RULE_12: parity bit stored, all fields read back unchanged
`ifndef FAULT_CFG_MAP_SVH
`define FAULT_CFG_MAP_SVH
`define FSW1_OFFSET 8'h92
`define FSW1_RESET 32'h0000_0000
`define PARITY_BIT 31
`define NOMTR_LSB 27
`define CBC_LSB 23
`define LOCKI_LSB 19
`define LOCKMODE_LSB 15
`define LOCKDEG_LSB 11
`define RETRY_LSB 8
`define CLK_HZ 40000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`endif

// *** src/fault_cfg_pkg.sv ***
// state type for the per-cycle current limit reaction
`default_nettype none
package fault_cfg_pkg;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_RECIRC = 2'b01,
		ST_WAIT_LOW = 2'b11,
		ST_RETRY = 2'b10
	} limit_state_type;
endpackage
`default_nettype wire

// *** src/fault_current_limit_config.sv ***
// fault setting word register and the per-cycle current limit reaction it steers
`timescale 1ns/10ps
`default_nettype none
`include "fault_cfg_map.svh"
module fault_current_limit_config #(
	parameter int CYC_PER_MS = `CYC_PER_MS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	input wire logic pwm_cycle_start,
	input wire logic overcurrent,
	input wire logic sensed_phase_voltage_high,
	input wire logic absent_motor_raw,
	input wire logic [3:0] stall_current_code,
	output logic recirculate,
	output logic fault_pin_n,
	output logic limit_report,
	output logic absent_motor_fault,
	output logic stall_current_fault,
	output logic [3:0] lock_threshold_code
);
	import fault_cfg_pkg::*;

	logic [31:0] word_q, word_d;
	logic [31:0] rdata_q, rdata_d;
	limit_state_type st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic recirc_q, recirc_d;
	logic fault_q, fault_d;
	logic fault_n_q, fault_n_d;
	logic report_q, report_d;
	logic [3:0] thr_q, thr_d;
	logic am_s1_q, am_s2_q, oc_s1_q, oc_s2_q, vh_s1_q, vh_s2_q;
	logic [3:0] sc_s1_q, sc_s2_q;
	logic absent_q, stall_q;
	logic absent_qual, stall_qual;
	logic stall_cond;
	logic [15:0] absent_ms, stall_ms;
	logic [3:0] policy;
	logic [2:0] retry_cnt;
	logic [2:0] absent_code;
	logic [3:0] stall_deg_code;

	assign policy = word_q[`CBC_LSB +: 4];
	assign retry_cnt = word_q[`RETRY_LSB +: 3]; // RULE_10
	assign absent_code = word_q[`NOMTR_LSB +: 3];
	assign stall_deg_code = word_q[`LOCKDEG_LSB +: 4];

	// register: whole word stored, parity included, read back as written
	always_comb begin
		word_d = word_q;
		if (cfg_wr && cfg_addr == `FSW1_OFFSET)
			word_d = cfg_wdata; // RULE_12
		rdata_d = (cfg_addr == `FSW1_OFFSET) ? word_q : 32'h0000_0000; // RULE_12
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			word_q <= `FSW1_RESET;
			rdata_q <= 32'h0000_0000;
		end else begin
			word_q <= word_d;
			rdata_q <= rdata_d;
		end
	end

	// pins from the analog side cross in through two flops
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			am_s1_q <= 1'b0;
			am_s2_q <= 1'b0;
			oc_s1_q <= 1'b0;
			oc_s2_q <= 1'b0;
			vh_s1_q <= 1'b0;
			vh_s2_q <= 1'b0;
			sc_s1_q <= 4'h0;
			sc_s2_q <= 4'h0;
		end else begin
			am_s1_q <= absent_motor_raw;
			am_s2_q <= am_s1_q;
			oc_s1_q <= overcurrent;
			oc_s2_q <= oc_s1_q;
			vh_s1_q <= sensed_phase_voltage_high;
			vh_s2_q <= vh_s1_q;
			sc_s1_q <= stall_current_code;
			sc_s2_q <= sc_s1_q;
		end
	end

	// deglitch tables in milliseconds
	always_comb begin
		case (absent_code) // RULE_01
			3'h0: absent_ms = 16'h0001;
			3'h1: absent_ms = 16'h000A;
			3'h2: absent_ms = 16'h0019;
			3'h3: absent_ms = 16'h0032;
			3'h4: absent_ms = 16'h0064;
			3'h5: absent_ms = 16'h00FA;
			3'h6: absent_ms = 16'h01F4;
			default: absent_ms = 16'h03E8;
		endcase
		case (stall_deg_code) // RULE_11
			4'h0: stall_ms = 16'h0001;
			4'h1: stall_ms = 16'h0002;
			4'h2: stall_ms = 16'h0005;
			4'h3: stall_ms = 16'h000A;
			4'h4: stall_ms = 16'h0019;
			4'h5: stall_ms = 16'h0032;
			4'h6: stall_ms = 16'h004B;
			4'h7: stall_ms = 16'h0064;
			4'h8: stall_ms = 16'h00FA;
			4'h9: stall_ms = 16'h01F4;
			4'hA: stall_ms = 16'h03E8;
			4'hB: stall_ms = 16'h09C4;
			4'hC: stall_ms = 16'h1388;
			4'hD: stall_ms = 16'h2710;
			4'hE: stall_ms = 16'h61A8;
			default: stall_ms = 16'hC350;
		endcase
	end

	// code 0 means not applicable, so no stall current is ever flagged
	assign stall_cond = (thr_q != 4'h0) && (sc_s2_q >= thr_q); // RULE_09

	ms_filter #(.CYC_PER_MS(CYC_PER_MS)) absent_filter (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.cond(am_s2_q),
		.limit_ms(absent_ms),
		.qualified(absent_qual)
	);

	ms_filter #(.CYC_PER_MS(CYC_PER_MS)) stall_filter (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.cond(stall_cond),
		.limit_ms(stall_ms),
		.qualified(stall_qual)
	);

	// per-cycle limit reaction
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		recirc_d = recirc_q;
		fault_d = fault_q;
		report_d = 1'b0;
		thr_d = word_q[`LOCKI_LSB +: 4]; // RULE_09
		case (st_q)
			ST_RUN: begin
				recirc_d = 1'b0;
				fault_d = 1'b0;
				if (oc_s2_q) begin
					if (policy == 4'h6) begin
						report_d = 1'b1; // RULE_07
					end else if (policy <= 4'h5) begin
						recirc_d = 1'b1;
						fault_d = (policy == 4'h0) || (policy == 4'h2) || (policy == 4'h4); // RULE_02 RULE_03 RULE_06
						cnt_d = retry_cnt;
						if (policy == 4'h2 || policy == 4'h3)
							st_d = ST_WAIT_LOW; // RULE_04
						else if (policy == 4'h4 || policy == 4'h5)
							st_d = ST_RETRY; // RULE_06
						else
							st_d = ST_RECIRC; // RULE_02
					end else begin
						// codes 7 and up: limiting off, driver left alone
						recirc_d = 1'b0; // RULE_08
					end
				end
			end
			ST_RECIRC: begin
				if (pwm_cycle_start)
					st_d = ST_RUN; // RULE_02 RULE_03
			end
			ST_WAIT_LOW: begin
				// RULE_05 leaves availability to software
				if (!vh_s2_q)
					st_d = ST_RUN; // RULE_04
			end
			ST_RETRY: begin
				if (cnt_q == 3'h0)
					st_d = ST_RUN; // RULE_06
				else if (pwm_cycle_start)
					cnt_d = cnt_q - 3'h1; // RULE_10
			end
			default: st_d = ST_RUN;
		endcase
		if (st_d == ST_RUN && st_q != ST_RUN) begin
			recirc_d = 1'b0;
			fault_d = 1'b0;
		end
		// pin gets its own flop so the output needs no inverter after the register
		fault_n_d = ~fault_d;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_q <= ST_RUN;
			cnt_q <= 3'h0;
			recirc_q <= 1'b0;
			fault_q <= 1'b0;
			fault_n_q <= 1'b1;
			report_q <= 1'b0;
			thr_q <= 4'h0;
			absent_q <= 1'b0;
			stall_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			recirc_q <= recirc_d;
			fault_q <= fault_d;
			fault_n_q <= fault_n_d;
			report_q <= report_d;
			thr_q <= thr_d;
			absent_q <= absent_qual; // RULE_01
			stall_q <= stall_qual; // RULE_11
		end
	end

	assign cfg_rdata = rdata_q;
	assign recirculate = recirc_q;
	assign fault_pin_n = fault_n_q;
	assign limit_report = report_q;
	assign absent_motor_fault = absent_q;
	assign stall_current_fault = stall_q;
	assign lock_threshold_code = thr_q;
endmodule
`default_nettype wire

// *** src/ms_filter.sv ***
// persistence filter: output rises once input has held for a millisecond count
`timescale 1ns/10ps
`default_nettype none
`include "fault_cfg_map.svh"
module ms_filter #(
	parameter int CYC_PER_MS = `CYC_PER_MS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cond,
	input wire logic [15:0] limit_ms,
	output logic qualified
);
	logic [15:0] pre_q, pre_d;
	logic [15:0] ms_q, ms_d;
	logic qual_q, qual_d;

	always_comb begin
		pre_d = pre_q;
		ms_d = ms_q;
		qual_d = qual_q;
		if (!cond) begin
			pre_d = '0;
			ms_d = '0;
			qual_d = 1'b0;
		end else if (!qual_q) begin
			if (pre_q == 16'(CYC_PER_MS - 1)) begin
				pre_d = '0;
				ms_d = ms_q + 16'h0001;
				if (ms_d >= limit_ms)
					qual_d = 1'b1;
			end else begin
				pre_d = pre_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pre_q <= '0;
			ms_q <= '0;
			qual_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			ms_q <= ms_d;
			qual_q <= qual_d;
		end
	end

	assign qualified = qual_q;
endmodule
`default_nettype wire

// *** verif/fault_current_limit_config_assertions.sv ***
// assertions on the fault setting word and the limit reaction
`timescale 1ns/10ps
`default_nettype none
module fcl_checker (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic overcurrent,
	input wire logic sensed_phase_voltage_high,
	input wire logic recirculate,
	input wire logic fault_pin_n,
	input wire logic limit_report,
	input wire logic [3:0] lock_threshold_code
);
	logic [31:0] w_q;
	logic [31:0] w_d;
	logic [3:0] md;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// mirror of the stored word so checks can key on the mode
	always_comb begin
		w_d = (cfg_wr && cfg_addr == 8'h92) ? cfg_wdata : w_q;
		md = w_q[26:23];
	end
	always_ff @(posedge sys_clk) begin
		w_q <= sys_rst ? 32'h0 : w_d;
	end
	sequence wr_s;
		cfg_wr && cfg_addr == 8'h92;
	endsequence
	sequence rd_s;
		!cfg_wr && cfg_addr == 8'h92;
	endsequence
	read_back_a: assert property (wr_s ##1 rd_s |=> cfg_rdata == $past(cfg_wdata, 2))
		else $error("readback");
	lock_copy_a: assert property (!cfg_wr && !$past(cfg_wr) |-> lock_threshold_code == w_q[22:19])
		else $error("lock code");
	limit_entry_a: assert property (md < 4'h6 && $rose(overcurrent) |-> ##[2:4] recirculate)
		else $error("no recirculation");
	fault_pin_a: assert property (md inside {4'h0, 4'h2, 4'h4} && $rose(recirculate) |-> !fault_pin_n)
		else $error("fault pin idle");
	silent_pin_a: assert property (md inside {4'h1, 4'h3, 4'h5} |-> fault_pin_n)
		else $error("fault pin active");
	no_action_a: assert property (md > 4'h5 |-> !recirculate && fault_pin_n)
		else $error("driver acted");
	limit_off_a: assert property (md > 4'h6 |-> !limit_report)
		else $error("report when off");
	hold_low_a: assert property ((md inside {4'h2, 4'h3} && recirculate && sensed_phase_voltage_high) [*3]
		|=> recirculate) else $error("early release");
endmodule
bind fault_current_limit_config fcl_checker chk_u (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.cfg_addr(cfg_addr),
	.cfg_wr(cfg_wr),
	.cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata),
	.overcurrent(overcurrent),
	.sensed_phase_voltage_high(sensed_phase_voltage_high),
	.recirculate(recirculate),
	.fault_pin_n(fault_pin_n),
	.limit_report(limit_report),
	.lock_threshold_code(lock_threshold_code)
);
`default_nettype wire

// *** verif/fault_current_limit_config_bench.sv ***
// self-checking bench for the fault setting word
`timescale 1ns/10ps
`default_nettype none
module fault_current_limit_config_bench;
	logic sys_clk = 0;
	logic sys_rst = 1;
	logic [7:0] cfg_addr = 8'h92;
	logic cfg_wr = 0;
	logic [31:0] cfg_wdata = 0;
	logic oc_cmd = 0;
	logic v_cmd = 0;
	logic absent_motor_raw = 0;
	logic [3:0] stall_current_code = 0;
	logic [31:0] cfg_rdata;
	logic pwm_cycle_start, overcurrent, sensed_phase_voltage_high, recirculate, fault_pin_n;
	logic limit_report, absent_motor_fault, stall_current_fault;
	logic [3:0] lock_threshold_code;
	int mismatches = 0;
	int n_compared = 0;
	gate_stage_model gate_u (
		.sys_clk(sys_clk),
		.oc_cmd(oc_cmd),
		.v_cmd(v_cmd),
		.pwm_cycle_start(pwm_cycle_start),
		.overcurrent(overcurrent),
		.sensed_phase_voltage_high(sensed_phase_voltage_high)
	);
	fault_current_limit_config #(.CYC_PER_MS(4)) dut_u (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.cfg_addr(cfg_addr),
		.cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata),
		.pwm_cycle_start(pwm_cycle_start),
		.overcurrent(overcurrent),
		.sensed_phase_voltage_high(sensed_phase_voltage_high),
		.absent_motor_raw(absent_motor_raw),
		.stall_current_code(stall_current_code),
		.recirculate(recirculate),
		.fault_pin_n(fault_pin_n),
		.limit_report(limit_report),
		.absent_motor_fault(absent_motor_fault),
		.stall_current_fault(stall_current_fault),
		.lock_threshold_code(lock_threshold_code)
	);
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		cfg_addr <= a;
		cfg_wr <= 1;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr <= 0;
		cfg_addr <= 8'h92;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		cfg_addr <= a;
		cyc(2);
		#1 d = cfg_rdata;
	endtask
	task automatic t_regs();
		logic [31:0] d;
		rd(8'h92, d);
		chk("reset", d, 32'h0);
		wr(8'h92, 32'hA5C3_0F96);
		wr(8'h94, 32'h1234_5678);
		rd(8'h92, d);
		chk("word", d, 32'hA5C3_0F96);
		rd(8'h94, d);
		chk("unmapped", d, 32'h0);
		chk("lock code", lock_threshold_code, 4'h8);
		$display("t_regs done");
	endtask
	task automatic t_modes();
		logic r, f, p;
		for (int m = 0; m < 16; m++) begin
			wr(8'h92, 32'(m) << 23);
			{r, f, p} = 3'h0;
			oc_cmd <= 1;
			repeat (24) begin
				@(posedge sys_clk);
				oc_cmd <= 0;
				#1 {r, f, p} = {r | recirculate, f | !fault_pin_n, p | limit_report};
			end
			chk("recirc", r, m < 6);
			chk("fault", f, m == 0 || m == 2 || m == 4);
			chk("report", p, m == 6);
			chk("resumed", recirculate, 0);
		end
		$display("t_modes done");
	endtask
	task automatic t_hold();
		wr(8'h92, 32'h2 << 23);
		v_cmd <= 1;
		oc_cmd <= 1;
		cyc(1);
		oc_cmd <= 0;
		cyc(24);
		#1 chk("held", recirculate, 1);
		@(posedge sys_clk) v_cmd <= 0;
		cyc(6);
		#1 chk("freed", recirculate, 0);
		$display("t_hold done");
	endtask
	task automatic t_retry();
		int k;
		k = 0;
		wr(8'h92, (32'h4 << 23) | (32'h3 << 8));
		@(posedge pwm_cycle_start);
		@(posedge sys_clk) oc_cmd <= 1;
		@(posedge sys_clk) oc_cmd <= 0;
		cyc(3);
		// look after the edge, once the flops have taken their new values
		#1;
		for (int n = 0; n < 40 && recirculate === 1; n++) begin
			@(posedge sys_clk);
			#1 k += pwm_cycle_start;
		end
		chk("retry pulses", k, 3);
		$display("t_retry done");
	endtask
	task automatic t_filters();
		wr(8'h92, (32'h1 << 27) | (32'h5 << 19));
		absent_motor_raw <= 1;
		stall_current_code <= 4'h6;
		cyc(30);
		#1 chk("nomotor early", absent_motor_fault, 0);
		chk("stall", stall_current_fault, 1);
		cyc(20);
		#1 chk("nomotor late", absent_motor_fault, 1);
		@(posedge sys_clk) stall_current_code <= 4'h4;
		cyc(10);
		#1 chk("stall low", stall_current_fault, 0);
		wr(8'h92, 32'h0800_0000);
		cyc(10);
		#1 chk("stall off", stall_current_fault, 0);
		$display("t_filters done");
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#(4000 * 25);
		mismatches++;
		summarize();
	end
	initial begin
		cyc(5);
		sys_rst <= 0;
		t_regs();
		t_modes();
		t_hold();
		t_retry();
		t_filters();
		summarize();
	end
endmodule
`default_nettype wire

// *** verif/gate_stage_model.sv ***
// gate driver and sense amplifier stand-in
`timescale 1ns/10ps
`default_nettype none
module gate_stage_model #(
	parameter int PWM_P = 8
) (
	input wire logic sys_clk,
	input wire logic oc_cmd,
	input wire logic v_cmd,
	output logic pwm_cycle_start,
	output logic overcurrent,
	output logic sensed_phase_voltage_high
);
	int cnt = 0;
	initial {pwm_cycle_start, overcurrent, sensed_phase_voltage_high} = 3'h0;
	// high-side modulation assumed, so threshold recovery is usable
	always @(posedge sys_clk) begin
		cnt <= (cnt == PWM_P - 1) ? 0 : cnt + 1;
		pwm_cycle_start <= (cnt == PWM_P - 1);
		overcurrent <= oc_cmd;
		sensed_phase_voltage_high <= v_cmd;
	end
endmodule
`default_nettype wire
